// >>> design/rsa_strobe_regs.sv
// Purpose: Rail strobe assignment registers and strobe sequencer
// Assumes: Register port from the serial host slave, lock state from elsewhere
// Notes: Gap delay bits and the power-down factor are plain inputs
// Operation
// - Register 0x23 holds buck-boost 4 slot in bits 7-4 and buck 3 slot in 3-0, reset 0x84.
// - Register 0x24 holds backup 6 slot in 5-4 and backup 5 slot in 1-0, others read zero, reset 0x10.
// - Register 0x25 holds load switch slot in 7-4 and LDO slot in 3-0, reset 0x88.
// - Nibble codes 3h to Ah enable the rail at strobes 3 to 10.
// - Nibble codes 0h to 2h and Bh to Fh leave the rail unsequenced.
// - Backup codes 1h and 2h pick strobes 1 and 2, codes 0h and 3h leave it unsequenced.
// - Strobes 1 and 2 run only while the sealing flag is zero.
// - With the seal broken the backup converters are never disabled.
// - Writes are accepted only while the registers are unlocked.
// - Each gap is 2 ms or 5 ms by its own select bit.
// - The power-down factor multiplies gaps by ten in power-down only.
`timescale 1ns/10ps
`default_nettype none
module rsa_strobe_regs #(
	parameter int GAP_SHORT = rsa_pkg::GAP_SHORT_CYC,
	parameter int GAP_LONG = rsa_pkg::GAP_LONG_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	output logic [7:0] reg_rdata_o,
	input wire logic unlocked_i,
	input wire logic sealing_flag_i,
	input wire logic [8:0] gap_sel_i,
	input wire logic powerdown_delay_factor_i,
	input wire logic power_up_i,
	input wire logic power_down_i,
	output logic [5:0] rail_en_o,
	output logic [3:0] strobe_o,
	output logic busy_o
);
	typedef struct packed {
		logic [7:0] r23;
		logic [7:0] r24;
		logic [7:0] r25;
		rsa_pkg::rsa_seq_t st;
		logic dir_up;
		logic [3:0] strobe;
		logic [5:0] rail_en;
		logic [7:0] rdata;
	} rsa_state_t;
	rsa_state_t s_reg, s_next;
	logic tmr_start;
	logic [31:0] tmr_count;
	logic tmr_done;
	logic seal_meta, seal_sync;
	// Slot to strobe number, zero means unsequenced
	function automatic logic [3:0] nib_strobe(input logic [3:0] code);
		if (code >= rsa_pkg::SLOT_MIN && code <= rsa_pkg::SLOT_MAX) begin
			return code;
		end
		return 4'h0;
	endfunction : nib_strobe
	function automatic logic [3:0] pair_strobe(input logic [1:0] code);
		if (code == 2'h1 || code == 2'h2) begin
			return {2'b00, code};
		end
		return 4'h0;
	endfunction : pair_strobe
	logic [3:0] rail_slot [rsa_pkg::NUM_RAILS];
	always_comb begin
		rail_slot[rsa_pkg::RAIL_BUCK3] = nib_strobe(s_reg.r23[3:0]);
		rail_slot[rsa_pkg::RAIL_BB4] = nib_strobe(s_reg.r23[7:4]);
		rail_slot[rsa_pkg::RAIL_BACKUP5] = pair_strobe(s_reg.r24[1:0]);
		rail_slot[rsa_pkg::RAIL_BACKUP6] = pair_strobe(s_reg.r24[5:4]);
		rail_slot[rsa_pkg::RAIL_LDO] = nib_strobe(s_reg.r25[3:0]);
		rail_slot[rsa_pkg::RAIL_LOAD_SW] = nib_strobe(s_reg.r25[7:4]);
	end
	////////////////////////////////////////////////////////////////////////////////
	// Seal flag arrives from the backup domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seal_meta <= 1'b0;
			seal_sync <= 1'b0;
		end else begin
			seal_meta <= sealing_flag_i;
			seal_sync <= seal_meta;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Gap length for the gap after the current strobe
	logic [3:0] gap_idx;
	logic gap_bit;
	logic [31:0] gap_base;
	always_comb begin
		gap_idx = s_reg.dir_up ? s_reg.strobe : s_reg.strobe - 4'h1;
		gap_bit = (gap_idx >= 4'h1 && gap_idx <= 4'h9) ? gap_sel_i[gap_idx - 4'h1] : 1'b0;
		gap_base = gap_bit ? 32'(GAP_LONG) : 32'(GAP_SHORT);
		if (!s_reg.dir_up && powerdown_delay_factor_i) begin
			tmr_count = 32'(gap_base * rsa_pkg::PD_FACTOR);
		end else begin
			tmr_count = gap_base;
		end
	end
	rsa_gap_timer #(.CW(32)) u_gap (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(tmr_start),
		.count_i(tmr_count),
		.done_o(tmr_done)
	);
	////////////////////////////////////////////////////////////////////////////////
	logic skip_strobe;
	always_comb begin
		s_next = s_reg;
		tmr_start = 1'b0;
		skip_strobe = seal_sync && (s_reg.strobe <= 4'h2);
		if (reg_wr_i && unlocked_i) begin
			if (reg_addr_i == rsa_pkg::ADDR_BB4_BUCK3) begin
				s_next.r23 = reg_wdata_i;
			end else if (reg_addr_i == rsa_pkg::ADDR_BACKUP_PAIR) begin
				s_next.r24 = reg_wdata_i & rsa_pkg::MASK_BACKUP_PAIR;
			end else if (reg_addr_i == rsa_pkg::ADDR_SWITCH_LDO) begin
				s_next.r25 = reg_wdata_i;
			end
		end
		if (reg_addr_i == rsa_pkg::ADDR_BB4_BUCK3) begin
			s_next.rdata = s_reg.r23;
		end else if (reg_addr_i == rsa_pkg::ADDR_BACKUP_PAIR) begin
			s_next.rdata = s_reg.r24;
		end else if (reg_addr_i == rsa_pkg::ADDR_SWITCH_LDO) begin
			s_next.rdata = s_reg.r25;
		end else begin
			s_next.rdata = 8'h00;
		end
		case (s_reg.st)
			rsa_pkg::SEQ_IDLE: begin
				if (power_up_i) begin
					s_next.dir_up = 1'b1;
					s_next.strobe = 4'h1;
					s_next.st = rsa_pkg::SEQ_STROBE;
				end else if (power_down_i) begin
					s_next.dir_up = 1'b0;
					s_next.strobe = rsa_pkg::STROBE_LAST;
					s_next.st = rsa_pkg::SEQ_STROBE;
				end
			end
			rsa_pkg::SEQ_STROBE: begin
				if (!skip_strobe) begin
					for (int i = 0; i < rsa_pkg::NUM_RAILS; i++) begin
						if (rail_slot[i] == s_reg.strobe) begin
							if (s_reg.dir_up) begin
								s_next.rail_en[i] = 1'b1;
							end else if (!(seal_sync && (i == rsa_pkg::RAIL_BACKUP5 ||
									i == rsa_pkg::RAIL_BACKUP6))) begin
								s_next.rail_en[i] = 1'b0;
							end
						end
					end
				end
				if ((s_reg.dir_up && s_reg.strobe == rsa_pkg::STROBE_LAST) ||
						(!s_reg.dir_up && s_reg.strobe == 4'h1)) begin
					s_next.st = rsa_pkg::SEQ_IDLE;
					s_next.strobe = 4'h0;
				end else begin
					tmr_start = 1'b1;
					s_next.st = rsa_pkg::SEQ_WAIT;
				end
			end
			rsa_pkg::SEQ_WAIT: begin
				if (tmr_done) begin
					s_next.strobe = s_reg.dir_up ? s_reg.strobe + 4'h1 : s_reg.strobe - 4'h1;
					s_next.st = rsa_pkg::SEQ_STROBE;
				end
			end
			default: begin
				s_next.st = rsa_pkg::SEQ_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.r23 <= rsa_pkg::RST_BB4_BUCK3;
			s_reg.r24 <= rsa_pkg::RST_BACKUP_PAIR;
			s_reg.r25 <= rsa_pkg::RST_SWITCH_LDO;
		end else begin
			s_reg <= s_next;
		end
	end
	assign reg_rdata_o = s_reg.rdata;
	assign rail_en_o = s_reg.rail_en;
	assign strobe_o = s_reg.strobe;
	assign busy_o = (s_reg.st != rsa_pkg::SEQ_IDLE);
	////////////////////////////////////////////////////////////////////////////////
	AST_LOCKED_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && !unlocked_i) |=> $stable({s_reg.r23, s_reg.r24, s_reg.r25}))
		else $error("locked write changed a register");
	AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.r24 & ~rsa_pkg::MASK_BACKUP_PAIR) == 8'h00)
		else $error("reserved bits not zero");
	AST_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && unlocked_i && reg_addr_i == rsa_pkg::ADDR_BB4_BUCK3)
		|=> s_reg.r23 == $past(reg_wdata_i))
		else $error("write to 0x23 lost");
	AST_READ_BACK: assert property (@(posedge clk_i) disable iff (rst_i)
		(!reg_wr_i && reg_addr_i == rsa_pkg::ADDR_SWITCH_LDO) |=> reg_rdata_o == $past(s_reg.r25))
		else $error("read of 0x25 wrong");
	AST_UP_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.st == rsa_pkg::SEQ_WAIT && tmr_done && s_reg.dir_up)
		|=> strobe_o == $past(strobe_o) + 4'h1)
		else $error("strobe did not step up");
	AST_DOWN_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.st == rsa_pkg::SEQ_WAIT && tmr_done && !s_reg.dir_up)
		|=> strobe_o == $past(strobe_o) - 4'h1)
		else $error("strobe did not step down");
	AST_BACKUP_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
		(seal_sync && $past(seal_sync) && !s_reg.dir_up && $past(rail_en_o[2]))
		|-> rail_en_o[2])
		else $error("backup 5 disabled after seal broken");
	AST_SEAL_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.st == rsa_pkg::SEQ_STROBE && s_reg.dir_up && seal_sync && s_reg.strobe <= 4'h2)
		|=> $stable(rail_en_o))
		else $error("strobe 1 or 2 ran with seal broken");
	AST_NO_LOW_SLOT: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_reg.r23[3:0] < rsa_pkg::SLOT_MIN || s_reg.r23[3:0] > rsa_pkg::SLOT_MAX)
		|-> rail_slot[rsa_pkg::RAIL_BUCK3] == 4'h0)
		else $error("unsequenced code mapped to strobe");
	COV_POWER_UP: cover property (@(posedge clk_i) s_reg.st == rsa_pkg::SEQ_IDLE && power_up_i);
	COV_POWER_DOWN: cover property (@(posedge clk_i) s_reg.st == rsa_pkg::SEQ_IDLE && power_down_i);
	COV_LOCKED: cover property (@(posedge clk_i) reg_wr_i && !unlocked_i);
endmodule : rsa_strobe_regs
`default_nettype wire

// >>> design/rsa_pkg.sv
// Purpose: Shared constants for the rail strobe assignment block
// Assumes: Register subaddresses reached over an internal register port
// Notes: Times in microseconds, counts derived from a 200 MHz clock
`default_nettype none
package rsa_pkg;
	localparam logic [7:0] ADDR_BB4_BUCK3 = 8'h23;
	localparam logic [7:0] ADDR_BACKUP_PAIR = 8'h24;
	localparam logic [7:0] ADDR_SWITCH_LDO = 8'h25;
	localparam logic [7:0] RST_BB4_BUCK3 = 8'h84;
	localparam logic [7:0] RST_BACKUP_PAIR = 8'h10;
	localparam logic [7:0] RST_SWITCH_LDO = 8'h88;
	localparam logic [7:0] MASK_BACKUP_PAIR = 8'h33;
	localparam int HI_NIB_POS = 4;
	localparam int LO_NIB_POS = 0;
	localparam logic [3:0] SLOT_MIN = 4'h3;
	localparam logic [3:0] SLOT_MAX = 4'hA;
	localparam logic [3:0] STROBE_LAST = 4'hA;
	localparam int NUM_RAILS = 6;
	localparam int RAIL_BUCK3 = 0;
	localparam int RAIL_BB4 = 1;
	localparam int RAIL_BACKUP5 = 2;
	localparam int RAIL_BACKUP6 = 3;
	localparam int RAIL_LDO = 4;
	localparam int RAIL_LOAD_SW = 5;
	localparam int CLK_MHZ = 200;
	localparam int GAP_SHORT_US = 2000;
	localparam int GAP_LONG_US = 5000;
	localparam int PD_FACTOR = 10;
	localparam int GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
	localparam int GAP_LONG_CYC = GAP_LONG_US * CLK_MHZ;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STROBE = 2'b01,
		SEQ_WAIT = 2'b10
	} rsa_seq_t;
endpackage : rsa_pkg
`default_nettype wire

// >>> design/rsa_gap_timer.sv
// Purpose: Inter-strobe gap timer
// Assumes: One clock, synchronous reset
// Notes: Start pulse loads the count, done pulses once at expiry
`timescale 1ns/10ps
`default_nettype none
module rsa_gap_timer #(
	parameter int CW = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [CW-1:0] count_i,
	output logic done_o
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic run;
		logic done;
	} rsa_tmr_t;
	rsa_tmr_t s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (start_i) begin
			s_next.cnt = count_i;
			s_next.run = 1'b1;
		end else if (s_reg.run) begin
			if (s_reg.cnt <= CW'(1)) begin
				s_next.run = 1'b0;
				s_next.done = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt - CW'(1);
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign done_o = s_reg.done;
endmodule : rsa_gap_timer
`default_nettype wire

// >>> dv/rsa_host_model.sv
// Purpose: Host model for the strobe slot registers
// Assumes: Drives 1 ns after the rising edge
// Notes: Unlock is a level raised only around a write
`timescale 1ns/10ps
`default_nettype none
module rsa_host_model (
	input wire logic clk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic unlocked_o
);
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		unlocked_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
		@(posedge clk_i) #1;
		unlocked_o = u;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge clk_i) #1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
		unlocked_o = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i) #1;
		reg_addr_o = a;
		repeat (2) @(posedge clk_i);
		#1 d = reg_rdata_i;
	endtask : rd
endmodule : rsa_host_model
`default_nettype wire

// >>> dv/tb_rail_strobe_assignment_regs.sv
// Purpose: Self-checking bench for the strobe slot registers
// Assumes: Gaps shortened to 4 and 7 cycles
// Notes: Random slots from an LFSR seeded with 9
`timescale 1ns/10ps
`default_nettype none
module tb_rail_strobe_assignment_regs;
	logic clk_i, rst_i, wr, unl, sealing_flag, pdf, pu, pd, busy;
	logic [7:0] addr, wd, rdata, rv;
	logic [8:0] gsel;
	logic [5:0] rails;
	logic [3:0] strobe;
	logic [3:0] at[6], upr[6];
	logic [7:0] cfg[3];
	logic [15:0] lf;
	int mismatches, comparisons, tf[11];
	rsa_strobe_regs #(.GAP_SHORT(4), .GAP_LONG(7)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rdata_o(rdata),
		.unlocked_i(unl), .sealing_flag_i(sealing_flag), .gap_sel_i(gsel),
		.powerdown_delay_factor_i(pdf), .power_up_i(pu), .power_down_i(pd),
		.rail_en_o(rails), .strobe_o(strobe), .busy_o(busy));
	rsa_host_model host_u (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
		.reg_wdata_o(wd), .reg_wr_o(wr), .unlocked_o(unl));
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	function automatic logic [3:0] exp_slot(input int i);
		logic [3:0] c;
		c = i[0] ? cfg[i / 2][7:4] : cfg[i / 2][3:0];
		if (i / 2 == 1)
			return ((c == 4'h1 || c == 4'h2) && !sealing_flag) ? c : 4'h0;
		return (c >= 4'h3 && c <= 4'hA) ? c : 4'h0;
	endfunction : exp_slot
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : check
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task automatic reset_dut();
		@(posedge clk_i) #1;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		#1 rst_i = 1'b0;
	endtask : reset_dut
	// Rail change is tagged with the strobe shown one cycle earlier
	task automatic run(input logic up);
		logic [5:0] prev;
		logic [3:0] ps;
		int d, off;
		foreach (at[i]) at[i] = 4'h0;
		foreach (tf[i]) tf[i] = -1;
		repeat (4) @(posedge clk_i);
		#1 pu = up;
		pd = !up;
		@(posedge clk_i) #1;
		pu = 1'b0;
		pd = 1'b0;
		prev = rails;
		ps = strobe;
		// First strobe is already showing before the loop
		tf[strobe] = 0;
		for (int n = 1; busy === 1'b1; n++) begin
			if (n > 4000) begin
				check(0, 1, "timeout");
				close_out();
			end
			@(posedge clk_i) #1;
			for (int i = 0; i < 6; i++)
				if (rails[i] !== prev[i]) at[i] = ps;
			if (tf[strobe] < 0) tf[strobe] = n;
			prev = rails;
			ps = strobe;
		end
		for (int i = 0; i < 6; i++)
			check(at[i], (up || upr[i] !== 4'h0) ? exp_slot(i) : 4'h0, "rail");
		for (int k = 3; k < 10; k++) begin
			d = up ? tf[k + 1] - tf[k] : tf[k] - tf[k + 1];
			d = d - (gsel[k - 1] ? 7 : 4) * ((!up && pdf) ? 10 : 1);
			if (k == 3) off = d;
			check(d, off, "gap length");
		end
		check(off > 0, 1, "strobe order");
	endtask : run
	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		mismatches = 0;
		comparisons = 0;
		lf = 16'h0009;
		{rst_i, sealing_flag, pdf, pu, pd} = 5'h10;
		gsel = 9'h000;
		for (int j = 0; j < 16; j++) begin
			reset_dut();
			if (j == 0) begin
				host_u.rd(8'h23, rv);
				check(rv, 8'h84, "reset value");
				host_u.rd(8'h24, rv);
				check(rv, 8'h10, "reset value");
				host_u.rd(8'h25, rv);
				check(rv, 8'h88, "reset value");
				host_u.rd(8'h30, rv);
				check(rv, 8'h00, "unmapped read");
				host_u.wr(8'h25, 8'h33, 1'b0);
				host_u.rd(8'h25, rv);
				check(rv, 8'h88, "locked write");
			end
			// Buck 3 and backup 5 slot codes sweep every value across the pairs, the other slots come from the LFSR
			for (int k = 0; k < 3; k++) begin
				lf = nxt(lf);
				cfg[k] = k == 0 ? {lf[7:4], j[3:0]} : k == 1 ? {lf[7:2], j[1:0]} : lf[7:0];
				host_u.wr(8'h23 + k[7:0], cfg[k], 1'b1);
				if (k == 1) cfg[k] = cfg[k] & rsa_pkg::MASK_BACKUP_PAIR;
				host_u.rd(8'h23 + k[7:0], rv);
				check(rv, cfg[k], "readback");
			end
			lf = nxt(lf);
			gsel = lf[8:0];
			pdf = lf[9];
			sealing_flag = j >= 12;
			run(1'b1);
			upr = at;
			sealing_flag = j[0];
			run(1'b0);
			$display("pair %0d done", j);
		end
		close_out();
	end
endmodule : tb_rail_strobe_assignment_regs
`default_nettype wire
